// [hw/acl_map.svh]
// Constants for the frame access-list classifier: field codes, limits, counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH
`define ACL_ENTRIES 256
`define ACL_IDX_W 8
`define ACL_PORT_W 5
`define ACL_POLICY_W 8
`define ACL_RL_W 5
`define ACL_RL_MAX 5'h0010
`define ACL_RL_OFF 5'h0000
`define ACL_CNT_W 32
`define ACL_ETYPE_MIN 16'h0600
`define ACL_LEN_LIMIT 16'h05EE
`define ACL_FCS_BYTES 16'h0004
`define ACL_BCAST_ADDR 48'hFFFF_FFFF_FFFF
`define ACL_GROUP_BIT 40
`define ACL_CNT_ONE 32'h0000_0001
`define ACL_CNT_ZERO 32'h0000_0000
`endif

// [hw/acl_pkg.sv]
// Types shared by the classifier and its result buffer.
// Assumes acl_map.svh is on the include path.
`default_nettype none
`include "acl_map.svh"
package acl_pkg;
    typedef enum logic [2:0] {FT_ANY, FT_ETYPE, FT_ARP, FT_IPV4, FT_IPV6} frame_type_t;
    typedef enum logic [1:0] {ACT_PERMIT, ACT_DENY, ACT_FILTER} action_t;
    typedef enum logic [2:0] {DF_ANY, DF_MULTICAST_ONLY, DF_BROADCAST_ONLY, DF_UNICAST_ONLY, DF_SPECIFIC} dest_filter_t;
    typedef struct packed {
        logic valid;
        logic port_any;
        logic [`ACL_PORT_W-1:0] port;
        logic policy_any;
        logic [`ACL_POLICY_W-1:0] policy_value;
        logic [`ACL_POLICY_W-1:0] policy_mask;
        frame_type_t frame_type;
        action_t action;
        logic [`ACL_RL_W-1:0] rate_limiter;
        logic redirect_en;
        logic [`ACL_PORT_W-1:0] redirect_port;
        logic mirror_en;
        logic log_en;
        logic shutdown_en;
        logic src_specific;
        logic [47:0] source_hw_address;
        dest_filter_t dest_filter;
        logic [47:0] dest_hw_address;
    } filter_entry_t;
    typedef struct packed {
        logic hit;
        logic [`ACL_IDX_W-1:0] index;
        logic drop;
        logic filtered;
        logic [`ACL_RL_W-1:0] rate_limiter;
        logic redirect_en;
        logic [`ACL_PORT_W-1:0] redirect_port;
        logic mirror;
        logic log_capture;
        logic [15:0] log_length;
        logic shutdown;
        logic [`ACL_PORT_W-1:0] ingress_port;
    } verdict_t;
endpackage
`default_nettype wire

// [hw/verdict_if.sv]
// Carrier between the classifier and its two-entry verdict buffer.
// Assumes a single clock domain.
`default_nettype none
interface verdict_if;
    logic valid;
    logic ready;
    acl_pkg::verdict_t data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// [hw/verdict_buffer.sv]
// Two-entry buffer holding classifier verdicts ahead of the forwarding logic.
// Assumes the consumer may stall; ready to the source drops only when both slots fill.
`default_nettype none
module verdict_buffer (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Producer side
    verdict_if.dst in_side,
    // Consumer side
    output logic o_valid,
    input wire logic i_ready,
    output acl_pkg::verdict_t o_data
);
    acl_pkg::verdict_t slot [2];
    acl_pkg::verdict_t next_slot [2];
    logic [1:0] count;
    logic [1:0] next_count;
    logic rd_ptr;
    logic next_rd_ptr;
    logic wr_ptr;
    logic next_wr_ptr;
    logic push;
    logic pop;

    // Handshakes; a full buffer holds the source off so no verdict is lost
    assign in_side.ready = (count != 2'h2);
    assign o_valid = (count != 2'h0);
    assign o_data = slot[rd_ptr];
    assign push = in_side.valid && in_side.ready;
    assign pop = o_valid && i_ready;

    // Pointer and slot updates
    always_comb begin
        next_slot = slot;
        next_count = count;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        if (push) begin
            next_slot[wr_ptr] = in_side.data;
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            slot[0] <= '0;
            slot[1] <= '0;
        end else begin
            count <= next_count;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            slot <= next_slot;
        end
    end
endmodule // verdict_buffer
`default_nettype wire

// [hw/frame_acl_classifier.sv]
// Frame access-list classifier: walks the entry list for each frame header and
// emits one verdict through a two-entry buffer. Assumes one header at a time from
// the ingress pipeline and entry writes from management software as plain ports.
`default_nettype none
`include "acl_map.svh"
module frame_acl_classifier (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Entry configuration
    input wire logic i_cfg_we,
    input wire logic [`ACL_IDX_W-1:0] i_cfg_index,
    input wire acl_pkg::filter_entry_t i_cfg_entry,
    input wire logic [`ACL_IDX_W-1:0] i_reserved_count,
    input wire logic i_remove_all,
    input wire logic i_clear_counters,
    // Counter readback
    input wire logic [`ACL_IDX_W-1:0] i_cnt_index,
    output logic [`ACL_CNT_W-1:0] o_cnt_value,
    // Frame header in
    input wire logic i_hdr_valid,
    output logic o_hdr_ready,
    input wire logic [`ACL_PORT_W-1:0] i_hdr_port,
    input wire logic [`ACL_POLICY_W-1:0] i_hdr_policy,
    input wire logic [15:0] i_hdr_len_type,
    input wire logic i_hdr_is_arp,
    input wire logic i_hdr_is_ipv4,
    input wire logic i_hdr_is_ipv6,
    input wire logic [47:0] i_hdr_src_addr,
    input wire logic [47:0] i_hdr_dst_addr,
    input wire logic [15:0] i_hdr_length,
    // Verdict out
    output logic o_verdict_valid,
    input wire logic i_verdict_ready,
    output acl_pkg::verdict_t o_verdict,
    // Status
    output logic o_busy
);
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_EMIT} scan_state_t;

    acl_pkg::filter_entry_t table_mem [`ACL_ENTRIES];
    logic [`ACL_CNT_W-1:0] hit_count [`ACL_ENTRIES];
    logic [`ACL_CNT_W-1:0] next_hit_count [`ACL_ENTRIES];
    logic [`ACL_ENTRIES-1:0] entry_valid;
    logic [`ACL_ENTRIES-1:0] next_entry_valid;

    scan_state_t state;
    scan_state_t next_state;
    logic [`ACL_IDX_W-1:0] idx;
    logic [`ACL_IDX_W-1:0] next_idx;
    logic [`ACL_PORT_W-1:0] f_port;
    logic [`ACL_POLICY_W-1:0] f_policy;
    logic [15:0] f_len_type;
    logic f_arp;
    logic f_ipv4;
    logic f_ipv6;
    logic [47:0] f_src;
    logic [47:0] f_dst;
    logic [15:0] f_length;
    logic [`ACL_PORT_W-1:0] next_f_port;
    logic [`ACL_POLICY_W-1:0] next_f_policy;
    logic [15:0] next_f_len_type;
    logic next_f_arp;
    logic next_f_ipv4;
    logic next_f_ipv6;
    logic [47:0] next_f_src;
    logic [47:0] next_f_dst;
    logic [15:0] next_f_length;
    acl_pkg::verdict_t verdict;
    acl_pkg::verdict_t next_verdict;
    logic [`ACL_CNT_W-1:0] cnt_value;

    acl_pkg::filter_entry_t cur;
    logic port_ok;
    logic policy_ok;
    logic type_ok;
    logic src_ok;
    logic dst_ok;
    logic match;
    logic short_frame;
    logic take_hdr;

    verdict_if vbus ();

    // Entry under test; reserved entries sit at the lowest indices and are scanned first
    assign cur = table_mem[idx];
    assign short_frame = (f_length < `ACL_LEN_LIMIT);

    // Per-criterion match terms for the entry under test
    always_comb begin
        port_ok = cur.port_any || (cur.port == f_port);
        policy_ok = cur.policy_any || ((cur.policy_value & cur.policy_mask) == (f_policy & cur.policy_mask));
        unique case (cur.frame_type)
            acl_pkg::FT_ANY: type_ok = 1'b1;
            acl_pkg::FT_ETYPE: type_ok = (f_len_type >= `ACL_ETYPE_MIN) && !f_arp && !f_ipv4 && !f_ipv6;
            acl_pkg::FT_ARP: type_ok = f_arp;
            acl_pkg::FT_IPV4: type_ok = f_ipv4;
            acl_pkg::FT_IPV6: type_ok = f_ipv6;
            default: type_ok = 1'b0;
        endcase
        // Source address filter is meaningless for other frame types, so it is ignored there
        if (cur.src_specific && (cur.frame_type == acl_pkg::FT_ETYPE || cur.frame_type == acl_pkg::FT_ARP)) begin
            src_ok = (f_src == cur.source_hw_address);
        end else begin
            src_ok = 1'b1;
        end
        unique case (cur.dest_filter)
            acl_pkg::DF_ANY: dst_ok = 1'b1;
            acl_pkg::DF_MULTICAST_ONLY: dst_ok = f_dst[`ACL_GROUP_BIT] && (f_dst != `ACL_BCAST_ADDR);
            acl_pkg::DF_BROADCAST_ONLY: dst_ok = (f_dst == `ACL_BCAST_ADDR);
            acl_pkg::DF_UNICAST_ONLY: dst_ok = !f_dst[`ACL_GROUP_BIT];
            acl_pkg::DF_SPECIFIC: dst_ok = (f_dst == cur.dest_hw_address);
            default: dst_ok = 1'b0;
        endcase
        match = entry_valid[idx] && port_ok && policy_ok && type_ok && src_ok && dst_ok;
    end

    assign take_hdr = (state == ST_IDLE) && i_hdr_valid;
    assign o_hdr_ready = (state == ST_IDLE);
    assign o_busy = (state != ST_IDLE);
    assign vbus.valid = (state == ST_EMIT);
    assign vbus.data = verdict;

    // Scan sequencer: one entry per cycle, stops at the first hit
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_verdict = verdict;
        unique case (state)
            ST_IDLE: begin
                if (i_hdr_valid) begin
                    next_state = ST_SCAN;
                    next_idx = '0;
                    next_verdict = '0;
                    next_verdict.ingress_port = i_hdr_port;
                end
            end
            ST_SCAN: begin
                if (match) begin
                    next_state = ST_EMIT;
                    next_verdict.hit = 1'b1;
                    next_verdict.index = idx;
                    next_verdict.drop = (cur.action == acl_pkg::ACT_DENY);
                    next_verdict.filtered = (cur.action == acl_pkg::ACT_FILTER);
                    // Out-of-range limiter numbers are treated as disabled
                    next_verdict.rate_limiter = (cur.rate_limiter > `ACL_RL_MAX) ? `ACL_RL_OFF : cur.rate_limiter;
                    next_verdict.redirect_en = cur.redirect_en && (cur.action != acl_pkg::ACT_PERMIT);
                    next_verdict.redirect_port = cur.redirect_port;
                    next_verdict.mirror = cur.mirror_en;
                    next_verdict.log_capture = cur.log_en && short_frame;
                    next_verdict.log_length = f_length - `ACL_FCS_BYTES;
                    next_verdict.shutdown = cur.shutdown_en && short_frame;
                end else if (idx == '1) begin
                    next_state = ST_EMIT;
                end else begin
                    next_idx = idx + 1'b1;
                end
            end
            ST_EMIT: begin
                if (vbus.ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Valid bits: remove-all wins over a same-cycle write; reserved slots keep their bit on writes
    always_comb begin
        next_entry_valid = entry_valid;
        if (i_cfg_we && (i_cfg_index >= i_reserved_count)) begin
            next_entry_valid[i_cfg_index] = i_cfg_entry.valid;
        end
        if (i_remove_all) begin
            next_entry_valid = '0;
        end
    end

    // Header fields latched at the take edge and held for the whole scan
    always_comb begin
        next_f_port = f_port;
        next_f_policy = f_policy;
        next_f_len_type = f_len_type;
        next_f_arp = f_arp;
        next_f_ipv4 = f_ipv4;
        next_f_ipv6 = f_ipv6;
        next_f_src = f_src;
        next_f_dst = f_dst;
        next_f_length = f_length;
        if (take_hdr) begin
            next_f_port = i_hdr_port;
            next_f_policy = i_hdr_policy;
            next_f_len_type = i_hdr_len_type;
            next_f_arp = i_hdr_is_arp;
            next_f_ipv4 = i_hdr_is_ipv4;
            next_f_ipv6 = i_hdr_is_ipv6;
            next_f_src = i_hdr_src_addr;
            next_f_dst = i_hdr_dst_addr;
            next_f_length = i_hdr_length;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            idx <= '0;
            verdict <= '0;
            entry_valid <= '0;
            f_port <= '0;
            f_policy <= '0;
            f_len_type <= '0;
            f_arp <= 1'b0;
            f_ipv4 <= 1'b0;
            f_ipv6 <= 1'b0;
            f_src <= '0;
            f_dst <= '0;
            f_length <= '0;
            cnt_value <= `ACL_CNT_ZERO;
        end else begin
            state <= next_state;
            idx <= next_idx;
            verdict <= next_verdict;
            entry_valid <= next_entry_valid;
            cnt_value <= hit_count[i_cnt_index];
            f_port <= next_f_port;
            f_policy <= next_f_policy;
            f_len_type <= next_f_len_type;
            f_arp <= next_f_arp;
            f_ipv4 <= next_f_ipv4;
            f_ipv6 <= next_f_ipv6;
            f_src <= next_f_src;
            f_dst <= next_f_dst;
            f_length <= next_f_length;
        end
    end

    // Entry storage; reserved entries refuse writes from software
    always_ff @(posedge i_ref_clk) begin
        if (i_cfg_we && (i_cfg_index >= i_reserved_count)) begin
            table_mem[i_cfg_index] <= i_cfg_entry;
        end
    end

    // Hit counters; a hit in the clear cycle still counts once, so the set wins
    always_comb begin
        next_hit_count = hit_count;
        if (i_clear_counters) begin
            for (int k = 0; k < `ACL_ENTRIES; k++) begin
                next_hit_count[k] = `ACL_CNT_ZERO;
            end
        end
        if (state == ST_SCAN && match) begin
            next_hit_count[idx] = next_hit_count[idx] + `ACL_CNT_ONE;
        end
    end

    // Counters also clear on reset so readback starts from zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            hit_count <= '{default: `ACL_CNT_ZERO};
        end else begin
            hit_count <= next_hit_count;
        end
    end

    assign o_cnt_value = cnt_value;

    verdict_buffer u_verdict_buffer (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .in_side(vbus.dst),
        .o_valid(o_verdict_valid),
        .i_ready(i_verdict_ready),
        .o_data(o_verdict)
    );
endmodule // frame_acl_classifier
`default_nettype wire

// [verification/acl_sva.sv]
// Checker on the classifier's top ports: verdict timing, holding, fields.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module acl_sva (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Header and counters
    input wire logic i_hdr_valid,
    input wire logic o_hdr_ready,
    input wire logic o_busy,
    input wire logic i_clear_counters,
    input wire logic [31:0] o_cnt_value,
    // Verdicts
    input wire logic o_verdict_valid,
    input wire logic i_verdict_ready,
    input wire acl_pkg::verdict_t o_verdict
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // Hit at entry k shows k+3 after take, a full miss 258 after
    property p_time;
        i_hdr_valid && o_hdr_ready && !o_verdict_valid |=> !o_verdict_valid [*2] ##[1:257] o_verdict_valid;
    endproperty
    a_time: assert property (p_time) else $error("verdict latency");
    // A taken header starts a scan and shuts the header port
    property p_busy;
        i_hdr_valid && o_hdr_ready |=> o_busy && !o_hdr_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("no scan after header take");
    // A stalled verdict must not change, or a word is lost
    property p_hold;
        o_verdict_valid && !i_verdict_ready |=> o_verdict_valid && $stable(o_verdict);
    endproperty
    a_hold: assert property (p_hold) else $error("verdict changed while stalled");
    property p_rl;
        o_verdict_valid |-> o_verdict.rate_limiter <= 5'h10;
    endproperty
    a_rl: assert property (p_rl) else $error("limiter out of range");
    property p_log;
        o_verdict_valid && o_verdict.log_capture |-> o_verdict.log_length < 16'h05EA;
    endproperty
    a_log: assert property (p_log) else $error("logged long frame");
    property p_miss;
        o_verdict_valid && !o_verdict.hit |-> !(o_verdict.drop || o_verdict.filtered || o_verdict.mirror
            || o_verdict.shutdown || o_verdict.redirect_en || o_verdict.log_capture);
    endproperty
    a_miss: assert property (p_miss) else $error("action without hit");
    property p_excl;
        o_verdict_valid |-> !(o_verdict.drop && o_verdict.filtered);
    endproperty
    a_excl: assert property (p_excl) else $error("drop and filter together");
    // Idle clear: the counter selected by i_cnt_index reads zero two edges on
    property p_clear;
        i_clear_counters && !o_busy && !i_hdr_valid |=> ##1 o_cnt_value == 32'h0000_0000;
    endproperty
    a_clear: assert property (p_clear) else $error("count after clear");
endmodule // acl_sva
`default_nettype wire

// [verification/verdict_sink.sv]
// Far-side model: forwarding logic taking verdicts, stalling on command.
// Assumes the bench pops the queue of taken verdicts.
`default_nettype none
module verdict_sink (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Bench control
    input wire logic i_stall,
    // Verdict stream
    input wire logic i_valid,
    output var logic o_ready,
    input wire acl_pkg::verdict_t i_data
);
    timeunit 1ns;
    timeprecision 1ps;
    acl_pkg::verdict_t got [$];
    // Ready moves only after an edge, so the word taken is the one seen there
    always @(posedge i_ref_clk) begin
        if (!i_rst && i_valid && o_ready) begin
            got.push_back(i_data);
        end
        o_ready <= !i_rst && !i_stall;
    end
endmodule // verdict_sink
`default_nettype wire

// [verification/test_frame_acl_classifier.sv]
// Bench for the access-list classifier: entries, headers, verdicts, counters.
// Assumes design, sink model and checker are compiled before it.
`default_nettype none
module test_frame_acl_classifier;
    timeunit 1ns;
    timeprecision 1ps;
    // Bench-driven inputs
    logic clk = 0;
    logic rst = 1;
    logic we = 0;
    logic rm = 0;
    logic clr = 0;
    logic stall = 0;
    logic hv = 0;
    logic [7:0] ci = 8'h00;
    logic [7:0] ki = 8'h00;
    logic [7:0] rc = 8'h00;
    logic [4:0] hp = 5'h00;
    logic [7:0] hq = 8'h00;
    logic [15:0] ht = 16'h0000;
    logic [15:0] hl = 16'h0000;
    logic [1:0] hk = 2'h0;
    logic [47:0] hs = 48'h0000_0000_0000;
    logic [47:0] hd = 48'h0000_0000_0000;
    acl_pkg::filter_entry_t e = '0;
    acl_pkg::filter_entry_t ce = '0;
    // Outputs and bench state
    logic hr;
    logic ovv;
    logic rdy;
    logic bsy;
    logic [31:0] cv;
    acl_pkg::verdict_t ov;
    acl_pkg::verdict_t v;
    int fail_count = 0;
    int n_checks = 0;
    localparam logic [11:0] DX = 12'h090A; // Hit per filter and address kind
    frame_acl_classifier i_dut (
        .i_ref_clk(clk), .i_rst(rst), .i_cfg_we(we), .i_cfg_index(ci), .i_cfg_entry(ce),
        .i_reserved_count(rc), .i_remove_all(rm), .i_clear_counters(clr), .i_cnt_index(ki),
        .o_cnt_value(cv), .i_hdr_valid(hv), .o_hdr_ready(hr), .i_hdr_port(hp), .i_hdr_policy(hq),
        .i_hdr_len_type(ht), .i_hdr_is_arp(hk == 2'h1), .i_hdr_is_ipv4(hk == 2'h2),
        .i_hdr_is_ipv6(hk == 2'h3), .i_hdr_src_addr(hs), .i_hdr_dst_addr(hd), .i_hdr_length(hl),
        .o_verdict_valid(ovv), .i_verdict_ready(rdy), .o_verdict(ov), .o_busy(bsy)
    );
    verdict_sink i_sink (
        .i_ref_clk(clk), .i_rst(rst), .i_stall(stall), .i_valid(ovv), .o_ready(rdy), .i_data(ov)
    );
    // Clock, 5 ns period
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Counted comparison, reported at once
    task chk(input string n, input logic [47:0] x, input logic [47:0] g);
        n_checks++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, x, g);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task tmo;
        fail_count++;
        tally_and_finish();
    endtask
    task done(input string n);
        $display("test %s finished", n);
    endtask
    // Entry that matches everything and permits
    task base;
        e = '0;
        e.valid = 1;
        e.port_any = 1;
        e.policy_any = 1;
    endtask
    task put(input logic [7:0] i);
        @(posedge clk);
        we <= 1;
        ci <= i;
        ce <= e;
        @(posedge clk);
        we <= 0;
    endtask
    // One-cycle remove-all (2) or counter clear (1)
    task cmd(input logic [1:0] c);
        @(posedge clk);
        {rm, clr} <= c;
        @(posedge clk);
        {rm, clr} <= 2'h0;
    endtask
    task get;
        int i;
        i = 0;
        while (i_sink.got.size() == 0 && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i == 400) tmo();
        v = i_sink.got.pop_front();
    endtask
    // Header held until the edge that takes it; g also waits for its verdict
    task xf(input logic [1:0] k = 2'h0, input logic [4:0] p = 5'h01, input logic [7:0] q = 8'h00,
            input logic [15:0] n = 16'h0040, input logic [15:0] t = 16'h0600, input logic g = 1);
        int i;
        i = 0;
        @(posedge clk);
        hv <= 1;
        {hp, hq, ht, hk, hl} <= {p, q, t, k, n};
        @(negedge clk);
        while (hr !== 1'b1 && i < 400) begin
            @(negedge clk);
            i++;
        end
        if (i == 400) tmo();
        @(posedge clk);
        hv <= 0;
        if (g) get();
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        xf();
        chk("hit", 0, v.hit);
        chk("mirror", 0, v.mirror);
        done("reset");
        base();
        e.port_any = 0;
        e.port = 5'h03;
        e.action = acl_pkg::ACT_DENY;
        put(8'hFF);
        xf(2'h0, 5'h02);
        chk("hit", 0, v.hit);
        xf(2'h0, 5'h03, 8'h5A);
        chk("hit", 1, v.hit);
        chk("index", 8'hFF, v.index);
        chk("drop", 1, v.drop);
        done("port");
        cmd(2'h2);
        base();
        e.policy_any = 0;
        e.policy_value = 8'h03;
        e.policy_mask = 8'hFE;
        e.action = acl_pkg::ACT_FILTER;
        put(8'h00);
        for (int q = 1; q < 4; q++) begin
            xf(2'h0, 5'h01, q[7:0]);
            chk("hit", q > 1, v.hit);
        end
        chk("filtered", 1, v.filtered);
        done("policy");
        for (int t = 4; t > 0; t--) begin
            cmd(2'h2);
            base();
            e.frame_type = acl_pkg::frame_type_t'(t[2:0]);
            put(8'h10);
            for (int k = 0; k < 4; k++) begin
                xf(k[1:0]);
                chk("type hit", (t == 1) ? (k == 0) : (k == t - 1), v.hit);
            end
        end
        xf(2'h0, 5'h01, 8'h00, 16'h0040, 16'h05FF);
        chk("hit", 0, v.hit);
        done("type");
        cmd(2'h2);
        base();
        e.action = acl_pkg::ACT_DENY;
        put(8'h09);
        e.action = acl_pkg::ACT_PERMIT;
        e.mirror_en = 1;
        e.log_en = 1;
        e.shutdown_en = 1;
        e.rate_limiter = 5'h10;
        put(8'h05);
        for (int n = 0; n < 2; n++) begin
            xf(2'h0, 5'h06, 8'h00, 16'h05ED + n[15:0]);
            chk("index", 8'h05, v.index);
            chk("drop", 0, v.drop);
            chk("mirror", 1, v.mirror);
            chk("limiter", 5'h10, v.rate_limiter);
            chk("log", n == 0, v.log_capture);
            chk("shutdown", n == 0, v.shutdown);
            chk("port", 5'h06, v.ingress_port);
            if (n == 0) chk("log length", 16'h05E9, v.log_length);
        end
        e.action = acl_pkg::ACT_FILTER;
        e.redirect_en = 1;
        e.redirect_port = 5'h07;
        e.rate_limiter = 5'h03;
        put(8'h05);
        xf();
        chk("redirect", 1, v.redirect_en);
        chk("redirect port", 5'h07, v.redirect_port);
        chk("limiter", 5'h03, v.rate_limiter);
        done("operations");
        cmd(2'h2);
        base();
        e.frame_type = acl_pkg::FT_ETYPE;
        e.src_specific = 1;
        e.source_hw_address = 48'h0A0B_0C0D_0E0F;
        put(8'h00);
        @(posedge clk) hs <= 48'h0A0B_0C0D_0E0F;
        xf();
        chk("hit", 1, v.hit);
        @(posedge clk) hs <= 48'h0A0B_0C0D_0E0E;
        xf();
        chk("hit", 0, v.hit);
        e.frame_type = acl_pkg::FT_IPV4;
        put(8'h00);
        xf(2'h2);
        chk("hit", 1, v.hit);
        done("source");
        for (int f = 1; f < 5; f++) begin
            cmd(2'h2);
            base();
            e.dest_filter = acl_pkg::dest_filter_t'(f[2:0]);
            e.dest_hw_address = 48'h0200_0000_0001;
            put(8'h00);
            for (int a = 0; a < 3; a++) begin
                @(posedge clk) hd <= (a == 0) ? 48'hFFFF_FFFF_FFFF : (a == 1) ? 48'h0100_5E00_0001 : 48'h0200_0000_0001;
                xf();
                chk("dest hit", DX[f * 3 + a - 3], v.hit);
            end
        end
        done("dest");
        // Stalled sink fills the buffer until headers are refused
        cmd(2'h2);
        cmd(2'h1);
        base();
        put(8'h07);
        @(posedge clk) stall <= 1;
        for (int n = 0; n < 3; n++) xf(2'h0, 5'h01, 8'h00, 16'h0040, 16'h0600, 0);
        repeat (20) @(negedge clk);
        chk("hdr ready", 0, hr);
        chk("busy", 1, bsy);
        @(posedge clk) stall <= 0;
        for (int n = 0; n < 3; n++) begin
            get();
            chk("index", 8'h07, v.index);
        end
        chk("verdict valid", 0, ovv);
        chk("busy", 0, bsy);
        @(posedge clk) ki <= 8'h07;
        repeat (2) @(negedge clk);
        chk("count", 32'h0000_0003, cv);
        cmd(2'h1);
        repeat (2) @(negedge clk);
        chk("count", 32'h0000_0000, cv);
        done("counter");
        // Reserved slot 0 refuses a later write that would clear it
        cmd(2'h2);
        base();
        e.action = acl_pkg::ACT_DENY;
        put(8'h00);
        @(posedge clk) rc <= 8'h01;
        e.valid = 0;
        put(8'h00);
        xf();
        chk("reserved hit", 1, v.hit);
        chk("reserved drop", 1, v.drop);
        done("reserved");
        cmd(2'h2);
        xf();
        chk("hit", 0, v.hit);
        done("remove");
        tally_and_finish();
    end
endmodule // test_frame_acl_classifier
bind frame_acl_classifier acl_sva i_sva (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hdr_valid(i_hdr_valid), .o_hdr_ready(o_hdr_ready),
    .o_busy(o_busy), .i_clear_counters(i_clear_counters), .o_cnt_value(o_cnt_value),
    .o_verdict_valid(o_verdict_valid), .i_verdict_ready(i_verdict_ready), .o_verdict(o_verdict)
);
`default_nettype wire
